// File: hw/pcd_port_mux.sv
// Pin function mux for port C, port D and port 8 bits 2..3 with an Avalon-MM register slave
// Summary of operation
// - Port 8 direction and function registers are write-only and read as zero.
// - Port 8 output latch bits here reset to one.
// - Reset clears port C function bits; all port C pins are inputs.
// - Port C function bit 0 has no effect on timer A0 input; bits 1..3 select irqs 1..3.
// - Port C pin 0 always feeds the timer A0 input.
// - Port C data reads current pin levels in bits 3..0, read-only.
// - Reset clears port D direction and both function registers.
// - Port D pin 0: input, output, irq 4, timer B0 output 0.
// - Port D pin 1 input-only: input, timer B1 input 0, irq 5, 110 reserved.
// - Pins 1/2 as timer input with capture active: irq follows capture mode.
// - Pin 2: input, output, timer input 1, transmit push-pull, irq 6, open drain.
// - Pin 3: input, output, serial receive, timer B1 output 0, irq 7.
// - Pin 4: input, output, timer B1 output 1, serial clock/CTS in, clock out.
// - Timer B1 capture inputs always fed from port D pins 1 and 2.
// - Serial 2 receive, clock and CTS inputs always fed from their pins.
// - Port D pin 1 has no latch; its data bit reads the pin level.
// - Port D output latch bits reset to zero.
// - Pin 2 open drain only from selection code; plain output is push-pull.
// - Port D direction and function registers are write-only and read as zero.
`timescale 1ns/1ps

module pcd_port_mux
	import pcd_pkg::*;
#(
	parameter int unsigned ADDR_W = 10
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic [3:0] i_pc_pin,
	input wire logic [4:0] i_pd_pin,
	output pcd_pd_drive_t o_pd_drive,
	input wire logic [1:0] i_p8_pin,
	output pcd_p8_drive_t o_p8_drive,
	input wire logic i_chip_select_two_n,
	input wire logic i_chip_select_three_n,
	input wire logic i_timer_a5_output,
	input wire logic i_timer_b0_output0,
	input wire logic i_timer_b1_output0,
	input wire logic i_timer_b1_output1,
	input wire logic i_serial2_transmit,
	input wire logic i_serial2_clock_out,
	input wire logic [1:0] i_timer_b1_capture_mode,
	output logic o_timer_a0_input,
	output logic [7:1] o_ext_irq,
	output logic [1:0] o_irq_capture_sel,
	output logic o_timer_b1_capture_in0,
	output logic o_timer_b1_capture_in1,
	output logic o_serial2_receive,
	output logic o_serial2_clock,
	output logic o_serial2_clear_to_send,
	output logic o_ext_wait_n
);

	if (ADDR_W < 10) begin : g_addr_w_check
		$error("ADDR_W must be at least 10");
	end

	// =====================================================================
	// Helpers
	// =====================================================================
	function automatic logic [2:0] sel_code(input logic hi, input logic fn, input logic dir);
		sel_code = {hi, fn, dir};
	endfunction : sel_code

	// =====================================================================
	// Registers
	// =====================================================================
	logic [3:0] pc_func_reg;
	logic [4:0] pd_dir_reg;
	logic [4:0] pd_func_reg;
	logic [4:0] pd_func_hi_reg;
	logic [4:0] pd_latch_reg;
	logic [1:0] p8_latch_reg;
	logic [1:0] p8_dir_reg;
	logic [1:0] p8_func_reg;
	logic [1:0] p8_func_hi_reg;
	logic ack_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [PCD_SYNC_W-1:0] sync1_reg;
	logic [PCD_SYNC_W-1:0] sync2_reg;
	logic [PCD_SYNC_W-1:0] sync3_reg;
	logic [PCD_SYNC_W-1:0] pin_reg;
	pcd_pd_drive_t pd_drive_reg;
	pcd_pd_drive_t pd_drive_next;
	pcd_p8_drive_t p8_drive_reg;
	pcd_p8_drive_t p8_drive_next;
	logic [7:1] irq_reg;
	logic [7:1] irq_next;
	logic [1:0] cap_sel_reg;
	logic [1:0] cap_sel_next;
	logic wait_n_reg;
	logic wait_n_next;
	logic [7:0] idx;
	logic req;
	logic wr_en;
	logic [3:0] pc_pins;
	logic [4:0] pd_pins;
	logic [1:0] p8_pins;
	logic [2:0] pd_sel [5];
	logic [2:0] p8_sel [2];

	assign idx = i_avs_address[9:2];
	assign req = i_avs_read | i_avs_write;
	assign wr_en = i_avs_write & ack_reg & i_avs_byteenable[0];
	assign o_avs_waitrequest = req & ~ack_reg;
	assign o_avs_readdata = rdata_reg;
	assign pc_pins = pin_reg[3:0];
	assign pd_pins = pin_reg[8:4];
	assign p8_pins = pin_reg[10:9];
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			pd_sel[i] = sel_code(pd_func_hi_reg[i], pd_func_reg[i], pd_dir_reg[i]);
		end
		for (int j = 0; j < 2; j++) begin
			p8_sel[j] = sel_code(p8_func_hi_reg[j], p8_func_reg[j], p8_dir_reg[j]);
		end
	end

	// =====================================================================
	// Bus handshake: one wait state, answer on the second edge
	// =====================================================================
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req & ~ack_reg;
		end
	end

	always_comb begin
		rdata_next = 32'h0000_0000;
		case (idx)
			PCD_IDX_PC_DATA: rdata_next[3:0] = pc_pins;
			PCD_IDX_PD_DATA: rdata_next[4:0] = pd_pins;
			PCD_IDX_P8_DATA: rdata_next[PCD_P8_HI:PCD_P8_LO] = p8_pins;
			default: rdata_next = 32'h0000_0000; // Config reads zero
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_reg <= 32'h0000_0000;
		end else if (i_avs_read && !ack_reg) begin
			rdata_reg <= rdata_next;
		end
	end

	// =====================================================================
	// Port C configuration
	// =====================================================================
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pc_func_reg <= PCD_PC_FUNC_RST;
		end else if (wr_en && idx == PCD_IDX_PC_FUNC) begin
			pc_func_reg <= i_avs_writedata[3:0];
		end
	end

	// =====================================================================
	// Port D configuration and latch
	// =====================================================================
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pd_dir_reg <= PCD_PD_CFG_RST;
			pd_func_reg <= PCD_PD_CFG_RST;
			pd_func_hi_reg <= PCD_PD_CFG_RST;
		end else if (wr_en) begin
			case (idx)
				PCD_IDX_PD_DIR: pd_dir_reg <= i_avs_writedata[4:0];
				PCD_IDX_PD_FUNC: pd_func_reg <= i_avs_writedata[4:0];
				PCD_IDX_PD_FUNC_HI: pd_func_hi_reg <= i_avs_writedata[4:0];
				default: pd_dir_reg <= pd_dir_reg;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pd_latch_reg <= PCD_PD_LATCH_RST;
		end else if (wr_en && idx == PCD_IDX_PD_DATA) begin
			pd_latch_reg <= {i_avs_writedata[4:2], 1'b0, i_avs_writedata[0]};
		end
	end

	// =====================================================================
	// Port 8 bits 2..3 configuration and latch
	// =====================================================================
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			p8_dir_reg <= PCD_P8_CFG_RST;
			p8_func_reg <= PCD_P8_CFG_RST;
			p8_func_hi_reg <= PCD_P8_CFG_RST;
		end else if (wr_en) begin
			case (idx)
				PCD_IDX_P8_DIR: p8_dir_reg <= i_avs_writedata[PCD_P8_HI:PCD_P8_LO];
				PCD_IDX_P8_FUNC: p8_func_reg <= i_avs_writedata[PCD_P8_HI:PCD_P8_LO];
				PCD_IDX_P8_FUNC_HI: p8_func_hi_reg <= i_avs_writedata[PCD_P8_HI:PCD_P8_LO];
				default: p8_dir_reg <= p8_dir_reg;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			p8_latch_reg <= PCD_P8_LATCH_RST;
		end else if (wr_en && idx == PCD_IDX_P8_DATA) begin
			p8_latch_reg <= i_avs_writedata[PCD_P8_HI:PCD_P8_LO];
		end
	end

	// =====================================================================
	// Pin input synchronisers: a change counts once stages two and three agree
	// =====================================================================
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
		end else begin
			sync1_reg <= {i_p8_pin, i_pd_pin, i_pc_pin};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin_reg <= '0;
		end else begin
			for (int k = 0; k < PCD_SYNC_W; k++) begin
				if (sync2_reg[k] == sync3_reg[k]) begin
					pin_reg[k] <= sync3_reg[k];
				end
			end
		end
	end

	// =====================================================================
	// Port D output drive
	// =====================================================================
	always_comb begin
		pd_drive_next.oe = 5'h00;
		pd_drive_next.out = 5'h00;
		// Pin 0
		case (pd_sel[0])
			PCD_SEL_PORT_OUT: begin
				pd_drive_next.oe[0] = 1'b1;
				pd_drive_next.out[0] = pd_latch_reg[0];
			end
			PCD_SEL_ALT_B: begin
				pd_drive_next.oe[0] = 1'b1;
				pd_drive_next.out[0] = i_timer_b0_output0;
			end
			default: pd_drive_next.oe[0] = 1'b0;
		endcase
		// Pin 1 is input-only and never driven
		// Pin 2
		case (pd_sel[2])
			PCD_SEL_PORT_OUT: begin
				pd_drive_next.oe[2] = 1'b1;
				pd_drive_next.out[2] = pd_latch_reg[2];
			end
			PCD_SEL_ALT_B: begin
				pd_drive_next.oe[2] = 1'b1;
				pd_drive_next.out[2] = i_serial2_transmit;
			end
			PCD_SEL_ALT_F: begin
				pd_drive_next.oe[2] = ~i_serial2_transmit;
				pd_drive_next.out[2] = 1'b0;
			end
			default: pd_drive_next.oe[2] = 1'b0;
		endcase
		// Pin 3
		case (pd_sel[3])
			PCD_SEL_PORT_OUT: begin
				pd_drive_next.oe[3] = 1'b1;
				pd_drive_next.out[3] = pd_latch_reg[3];
			end
			PCD_SEL_ALT_B: begin
				pd_drive_next.oe[3] = 1'b1;
				pd_drive_next.out[3] = i_timer_b1_output0;
			end
			default: pd_drive_next.oe[3] = 1'b0;
		endcase
		// Pin 4
		case (pd_sel[4])
			PCD_SEL_PORT_OUT: begin
				pd_drive_next.oe[4] = 1'b1;
				pd_drive_next.out[4] = pd_latch_reg[4];
			end
			PCD_SEL_ALT_B: begin
				pd_drive_next.oe[4] = 1'b1;
				pd_drive_next.out[4] = i_timer_b1_output1;
			end
			PCD_SEL_ALT_D: begin
				pd_drive_next.oe[4] = 1'b1;
				pd_drive_next.out[4] = i_serial2_clock_out;
			end
			default: pd_drive_next.oe[4] = 1'b0;
		endcase
	end

	// =====================================================================
	// Port 8 bits 2..3 drive and wait input
	// =====================================================================
	always_comb begin
		p8_drive_next.oe = 2'h0;
		p8_drive_next.out = 2'h0;
		wait_n_next = 1'b1;
		// Bit 2: plain output or chip select two
		case (p8_sel[0])
			PCD_SEL_PORT_OUT: begin
				p8_drive_next.oe[0] = 1'b1;
				p8_drive_next.out[0] = p8_latch_reg[0];
			end
			PCD_SEL_ALT_B: begin
				p8_drive_next.oe[0] = 1'b1;
				p8_drive_next.out[0] = i_chip_select_two_n;
			end
			default: p8_drive_next.oe[0] = 1'b0;
		endcase
		// Bit 3: output, chip select three, timer A5 output or wait input
		case (p8_sel[1])
			PCD_SEL_PORT_OUT: begin
				p8_drive_next.oe[1] = 1'b1;
				p8_drive_next.out[1] = p8_latch_reg[1];
			end
			PCD_SEL_ALT_A: wait_n_next = p8_pins[1];
			PCD_SEL_ALT_B: begin
				p8_drive_next.oe[1] = 1'b1;
				p8_drive_next.out[1] = i_chip_select_three_n;
			end
			PCD_SEL_ALT_F: begin
				p8_drive_next.oe[1] = 1'b1;
				p8_drive_next.out[1] = i_timer_a5_output;
			end
			default: p8_drive_next.oe[1] = 1'b0;
		endcase
	end

	// =====================================================================
	// Interrupt and timer input routing
	// =====================================================================
	always_comb begin
		irq_next[1] = pc_func_reg[1] & pc_pins[1];
		irq_next[2] = pc_func_reg[2] & pc_pins[2];
		irq_next[3] = pc_func_reg[3] & pc_pins[3];
		irq_next[4] = (pd_sel[0] == PCD_SEL_ALT_A) & pd_pins[0];
		cap_sel_next[0] = (pd_sel[1] == PCD_SEL_ALT_A)
			& (i_timer_b1_capture_mode != PCD_CAPTURE_OFF);
		cap_sel_next[1] = (pd_sel[2] == PCD_SEL_ALT_A)
			& (i_timer_b1_capture_mode != PCD_CAPTURE_OFF);
		irq_next[5] = ((pd_sel[1] == PCD_SEL_ALT_C) | cap_sel_next[0]) & pd_pins[1];
		irq_next[6] = ((pd_sel[2] == PCD_SEL_ALT_C) | cap_sel_next[1]) & pd_pins[2];
		irq_next[7] = (pd_sel[3] == PCD_SEL_ALT_C) & pd_pins[3];
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pd_drive_reg <= '0;
			p8_drive_reg <= '0;
			irq_reg <= '0;
			cap_sel_reg <= 2'h0;
			wait_n_reg <= 1'b1;
		end else begin
			pd_drive_reg <= pd_drive_next;
			p8_drive_reg <= p8_drive_next;
			irq_reg <= irq_next;
			cap_sel_reg <= cap_sel_next;
			wait_n_reg <= wait_n_next;
		end
	end

	assign o_pd_drive = pd_drive_reg;
	assign o_p8_drive = p8_drive_reg;
	assign o_ext_irq = irq_reg;
	assign o_irq_capture_sel = cap_sel_reg;
	assign o_ext_wait_n = wait_n_reg;
	assign o_timer_a0_input = pc_pins[0];
	assign o_timer_b1_capture_in0 = pd_pins[1];
	assign o_timer_b1_capture_in1 = pd_pins[2];
	assign o_serial2_receive = pd_pins[3];
	assign o_serial2_clock = pd_pins[4];
	assign o_serial2_clear_to_send = pd_pins[4];

endmodule : pcd_port_mux

// File: hw/pcd_pkg.sv
// Constants and carrier types for the port C / port D / port 8 pin function mux
package pcd_pkg;

	// =====================================================================
	// Register indices (byte address is four times the index)
	// =====================================================================
	localparam logic [7:0] PCD_IDX_P8_DATA = 8'h20;
	localparam logic [7:0] PCD_IDX_P8_FUNC_HI = 8'h21;
	localparam logic [7:0] PCD_IDX_P8_DIR = 8'h22;
	localparam logic [7:0] PCD_IDX_P8_FUNC = 8'h23;
	localparam logic [7:0] PCD_IDX_PC_DATA = 8'h30;
	localparam logic [7:0] PCD_IDX_PC_FUNC = 8'h33;
	localparam logic [7:0] PCD_IDX_PD_DATA = 8'h34;
	localparam logic [7:0] PCD_IDX_PD_FUNC_HI = 8'h35;
	localparam logic [7:0] PCD_IDX_PD_DIR = 8'h36;
	localparam logic [7:0] PCD_IDX_PD_FUNC = 8'h37;

	// =====================================================================
	// Field positions and reset values
	// =====================================================================
	localparam int unsigned PCD_PC_W = 4;
	localparam int unsigned PCD_PD_W = 5;
	localparam int unsigned PCD_P8_LO = 2;
	localparam int unsigned PCD_P8_HI = 3;
	localparam int unsigned PCD_SYNC_W = 11;
	localparam logic [3:0] PCD_PC_FUNC_RST = 4'h0;
	localparam logic [4:0] PCD_PD_CFG_RST = 5'h00;
	localparam logic [4:0] PCD_PD_LATCH_RST = 5'h00;
	localparam logic [1:0] PCD_P8_LATCH_RST = 2'h3;
	localparam logic [1:0] PCD_P8_CFG_RST = 2'h0;
	localparam logic [1:0] PCD_CAPTURE_OFF = 2'h0;

	// =====================================================================
	// Selection codes {func_hi, func, direction}
	// =====================================================================
	localparam logic [2:0] PCD_SEL_PORT_IN = 3'h0;
	localparam logic [2:0] PCD_SEL_PORT_OUT = 3'h1;
	localparam logic [2:0] PCD_SEL_ALT_A = 3'h2;
	localparam logic [2:0] PCD_SEL_ALT_B = 3'h3;
	localparam logic [2:0] PCD_SEL_ALT_C = 3'h4;
	localparam logic [2:0] PCD_SEL_ALT_D = 3'h5;
	localparam logic [2:0] PCD_SEL_ALT_F = 3'h7;

	// =====================================================================
	// Pin drive carriers
	// =====================================================================
	typedef struct packed {
		logic [4:0] oe;
		logic [4:0] out;
	} pcd_pd_drive_t;

	typedef struct packed {
		logic [1:0] oe;
		logic [1:0] out;
	} pcd_p8_drive_t;

endpackage : pcd_pkg

// File: testbench/pcd_pin_model.sv
// Outside circuitry on the port D and port 8 pins
`timescale 1ns/1ps

module pcd_pin_model
	import pcd_pkg::*;
(
	input wire pcd_pd_drive_t i_pd_drive,
	input wire pcd_p8_drive_t i_p8_drive,
	input wire logic [4:0] i_pd_ext,
	input wire logic [1:0] i_p8_ext,
	output logic [4:0] o_pd_pin,
	output logic [1:0] o_p8_pin
);
	// A driven pin shows the block's level, a released one the outside level
	assign o_pd_pin = (i_pd_drive.oe & i_pd_drive.out) | (~i_pd_drive.oe & i_pd_ext);
	assign o_p8_pin = (i_p8_drive.oe & i_p8_drive.out) | (~i_p8_drive.oe & i_p8_ext);
endmodule : pcd_pin_model

// File: testbench/pcd_port_mux_sva.sv
// Port-level assertions for the pin function mux
`timescale 1ns/1ps

module pcd_port_mux_sva
	import pcd_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire logic [3:0] i_pc_pin,
	input wire logic [4:0] i_pd_pin,
	input wire logic [1:0] i_p8_pin,
	input wire pcd_pd_drive_t o_pd_drive,
	input wire logic o_timer_a0_input,
	input wire logic [7:1] o_ext_irq,
	input wire logic [1:0] o_irq_capture_sel,
	input wire logic o_timer_b1_capture_in0,
	input wire logic o_serial2_receive,
	input wire logic o_ext_wait_n
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// ==========================================================
	// Bus and reset
	// ==========================================================
	one_wait_a: assert property ($rose(i_avs_read | i_avs_write)
		|-> o_avs_waitrequest ##1 !o_avs_waitrequest) else $error("wait state count wrong");
	rd_upper_a: assert property (i_avs_read && !o_avs_waitrequest
		|=> o_avs_readdata[31:5] == 27'h0) else $error("read data upper bits set");
	rst_drive_a: assert property ($rose(i_rst_n)
		|=> o_pd_drive == 10'h000 && o_irq_capture_sel == 2'h0) else $error("drive after reset");
	// ==========================================================
	// Pin routing
	// ==========================================================
	ta0_follow_a: assert property ($stable(i_pc_pin[0]) [*7]
		|-> o_timer_a0_input == i_pc_pin[0]) else $error("timer A0 input not pin C0");
	cap_follow_a: assert property ($stable(i_pd_pin[1]) [*7]
		|-> o_timer_b1_capture_in0 == i_pd_pin[1]) else $error("capture input not pin D1");
	rx_follow_a: assert property ($stable(i_pd_pin[3]) [*7]
		|-> o_serial2_receive == i_pd_pin[3]) else $error("receive input not pin D3");
	irq_one_a: assert property ((!i_pc_pin[1]) [*8] |-> !o_ext_irq[1])
		else $error("irq 1 high with pin low");
	irq_four_a: assert property ((!i_pd_pin[0]) [*8] |-> !o_ext_irq[4])
		else $error("irq 4 high with pin low");
	d1_undriven_a: assert property (!o_pd_drive.oe[1])
		else $error("input-only pin driven");
	wait_high_a: assert property (i_p8_pin[1] [*8] |-> o_ext_wait_n)
		else $error("wait asserted with pin high");
endmodule : pcd_port_mux_sva

bind pcd_port_mux pcd_port_mux_sva u_sva (.i_clk(i_clk), .i_rst_n(i_rst_n),
	.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest), .i_pc_pin(i_pc_pin), .i_pd_pin(i_pd_pin),
	.i_p8_pin(i_p8_pin), .o_pd_drive(o_pd_drive), .o_timer_a0_input(o_timer_a0_input),
	.o_ext_irq(o_ext_irq), .o_irq_capture_sel(o_irq_capture_sel),
	.o_timer_b1_capture_in0(o_timer_b1_capture_in0), .o_serial2_receive(o_serial2_receive),
	.o_ext_wait_n(o_ext_wait_n));

// File: testbench/pcd_port_mux_tb.sv
// Self-checking bench for the pin function mux
`timescale 1ns/1ps

module pcd_port_mux_tb;
	import pcd_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [9:0] adr = 10'h000;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [3:0] be = 4'hF;
	logic [31:0] rdat;
	logic wreq;
	logic [3:0] pc = 4'h0;
	logic [4:0] pd_ext = 5'h1F;
	logic [1:0] p8_ext = 2'h3;
	logic [4:0] pd_pin;
	logic [1:0] p8_pin;
	// {clk_out, tx, b1_out1, b1_out0, b0_out0, a5_out, cs3_n, cs2_n}
	logic [7:0] per = 8'hBB;
	logic [1:0] cap_mode = 2'h1;
	pcd_pd_drive_t pd_drv;
	pcd_p8_drive_t p8_drv;
	logic ta0, cap0, cap1, rx, sclk, cts, wait_n;
	logic [7:1] irq;
	logic [1:0] csel;
	logic [31:0] q;
	int err_total = 0;
	int total_checks = 0;
	int cyc = 0;

	pcd_port_mux dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(be),
		.o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_pc_pin(pc), .i_pd_pin(pd_pin),
		.o_pd_drive(pd_drv), .i_p8_pin(p8_pin), .o_p8_drive(p8_drv),
		.i_chip_select_two_n(per[0]), .i_chip_select_three_n(per[1]),
		.i_timer_a5_output(per[2]), .i_timer_b0_output0(per[3]), .i_timer_b1_output0(per[4]),
		.i_timer_b1_output1(per[5]), .i_serial2_transmit(per[6]), .i_serial2_clock_out(per[7]),
		.i_timer_b1_capture_mode(cap_mode), .o_timer_a0_input(ta0), .o_ext_irq(irq),
		.o_irq_capture_sel(csel), .o_timer_b1_capture_in0(cap0), .o_timer_b1_capture_in1(cap1),
		.o_serial2_receive(rx), .o_serial2_clock(sclk), .o_serial2_clear_to_send(cts),
		.o_ext_wait_n(wait_n));
	pcd_pin_model pins_u (.i_pd_drive(pd_drv), .i_p8_drive(p8_drv), .i_pd_ext(pd_ext),
		.i_p8_ext(p8_ext), .o_pd_pin(pd_pin), .o_p8_pin(p8_pin));

	always #12.5 i_clk = ~i_clk;

	// ==========================================================
	// Shared tasks
	// ==========================================================
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task waitc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : waitc

	task bus(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic [3:0] b);
		@(posedge i_clk);
		adr <= {idx, 2'b00};
		wr <= w;
		rd <= !w;
		wdat <= d;
		be <= b;
		@(posedge i_clk);
		while (wreq !== 1'b0) begin
			@(posedge i_clk);
		end
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus

	task finish_test;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test

	// ==========================================================
	// Scenarios
	// ==========================================================
	task t_reset;
		check("pd_oe_rst", pd_drv.oe, 5'h00);
		check("irq_rst", irq, 7'h00);
		bus(1, PCD_IDX_P8_DIR, 32'hC, 4'h1);
		waitc(2);
		check("p8_latch", p8_drv, 4'hF);
		bus(0, PCD_IDX_P8_DIR, 0, 4'hF);
		check("p8_dir_rd", q, 32'h0);
		bus(1, PCD_IDX_PD_DIR, 32'h1F, 4'h1);
		waitc(2);
		check("pd_oe_all", pd_drv.oe, 5'h1D);
		check("pd_latch", pd_drv.out & pd_drv.oe, 5'h00);
		bus(0, PCD_IDX_PD_DIR, 0, 4'hF);
		check("pd_dir_rd", q, 32'h0);
		bus(1, PCD_IDX_PD_DIR, 0, 4'h1);
		bus(1, PCD_IDX_P8_DIR, 0, 4'h1);
	endtask : t_reset

	task t_port_c;
		pc <= 4'hA;
		waitc(8);
		bus(0, PCD_IDX_PC_DATA, 0, 4'hF);
		check("pc_data", q, 32'hA);
		check("irq_c_off", irq[3:1], 3'h0);
		bus(1, PCD_IDX_PC_DATA, 32'h5, 4'hF);
		bus(0, PCD_IDX_PC_DATA, 0, 4'hF);
		check("pc_data_ro", q, 32'hA);
		bus(1, PCD_IDX_PC_FUNC, 32'hE, 4'h1);
		pc <= 4'hB;
		waitc(8);
		check("irq_c_on", irq[3:1], 3'h5);
		check("ta0_pin", ta0, 1'b1);
		bus(1, PCD_IDX_PC_FUNC, 32'h0, 4'h1);
	endtask : t_port_c

	task pd_case(input int p, input logic [2:0] c, input logic oe, input logic o,
		input logic [3:0] ir);
		bus(1, PCD_IDX_PD_FUNC_HI, 32'(c[2]) << p, 4'h1);
		bus(1, PCD_IDX_PD_FUNC, 32'(c[1]) << p, 4'h1);
		bus(1, PCD_IDX_PD_DIR, 32'(c[0]) << p, 4'h1);
		waitc(8);
		check("pd_oe", pd_drv.oe, 5'(oe) << p);
		if (oe) check("pd_out", pd_drv.out[p], o);
		check("irq_d", irq[7:4], ir);
	endtask : pd_case

	task t_port_d;
		pd_case(0, 3'h1, 1, 0, 4'h0);
		pd_case(0, 3'h2, 0, 0, 4'h1);
		pd_case(0, 3'h3, 1, 1, 4'h0);
		pd_case(1, 3'h2, 0, 0, 4'h2);
		check("csel_d1", csel, 2'h1);
		@(posedge i_clk);
		cap_mode <= 2'h0;
		waitc(3);
		check("csel_off", {csel, irq[5]}, 3'h0);
		@(posedge i_clk);
		cap_mode <= 2'h1;
		pd_case(1, 3'h4, 0, 0, 4'h2);
		pd_case(1, 3'h6, 0, 0, 4'h0);
		pd_case(2, 3'h1, 1, 0, 4'h0);
		pd_case(2, 3'h2, 0, 0, 4'h4);
		check("csel_d2", csel, 2'h2);
		pd_case(2, 3'h3, 1, 0, 4'h0);
		pd_case(2, 3'h4, 0, 0, 4'h4);
		pd_case(2, 3'h5, 0, 0, 4'h0);
		pd_case(2, 3'h7, 1, 0, 4'h0);
		@(posedge i_clk);
		per[6] <= 1'b1;
		waitc(4);
		check("od_release", pd_drv.oe[2], 1'b0);
		pd_case(3, 3'h2, 0, 0, 4'h0);
		pd_case(3, 3'h3, 1, 1, 4'h0);
		pd_case(3, 3'h4, 0, 0, 4'h8);
		pd_case(3, 3'h5, 0, 0, 4'h0);
		pd_case(4, 3'h3, 1, 1, 4'h0);
		pd_case(4, 3'h4, 0, 0, 4'h0);
		pd_case(4, 3'h5, 1, 1, 4'h0);
		pd_case(4, 3'h2, 0, 0, 4'h0);
	endtask : t_port_d

	task t_always;
		@(posedge i_clk);
		pd_ext <= 5'h0A;
		waitc(8);
		check("fixed_a", {cap0, cap1, rx, sclk, cts}, 5'h14);
		@(posedge i_clk);
		pd_ext <= 5'h14;
		waitc(8);
		check("fixed_b", {cap0, cap1, rx, sclk, cts}, 5'h0B);
		bus(1, PCD_IDX_PD_DATA, 32'h02, 4'h1);
		bus(0, PCD_IDX_PD_DATA, 0, 4'hF);
		check("d1_read", q[1], 1'b0);
	endtask : t_always

	task t_port8;
		bus(1, PCD_IDX_P8_FUNC, 32'h8, 4'h1);
		p8_ext <= 2'h1;
		waitc(8);
		check("wait_low", wait_n, 1'b0);
		@(posedge i_clk);
		p8_ext <= 2'h3;
		waitc(8);
		check("wait_high", wait_n, 1'b1);
		bus(1, PCD_IDX_P8_FUNC, 32'hC, 4'h1);
		bus(1, PCD_IDX_P8_DIR, 32'hC, 4'h1);
		per[1] <= 1'b0;
		waitc(3);
		check("cs_drive", p8_drv, 4'hD);
	endtask : t_port8

	task t_refuse;
		bus(0, 8'h10, 0, 4'hF);
		check("unmapped", q, 32'h0);
		bus(1, PCD_IDX_PD_DIR, 32'h1, 4'h0);
		waitc(2);
		check("be_ignored", pd_drv.oe, 5'h00);
	endtask : t_refuse

	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			finish_test();
		end
	end

	initial begin
		repeat (5) @(posedge i_clk);
		i_rst_n <= 1'b1;
		waitc(1);
		t_reset();
		t_port_c();
		t_port_d();
		t_always();
		t_refuse();
		t_port8();
		finish_test();
	end
endmodule : pcd_port_mux_tb
